// *** hdl/precharge_regs.svh ***
// Register offsets, field positions, reset values and timing figures of the sequencer
`ifndef PRECHARGE_REGS_SVH
`define PRECHARGE_REGS_SVH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ELAPSED 8'h08
`define REG_TARGET 8'h0C
`define CTRL_ENABLE_BIT 0
`define CTRL_COMPAT_BIT 1
`define CTRL_RESET 2'h1
`define ST_STATE_LSB 0
`define ST_CHARGE_BIT 2
`define ST_SMALL_BIT 3
`define ST_LARGE_BIT 4
`define ST_NOTIFY_BIT 5
`define ST_SEL_LSB 6
`define CLOCK_HZ 25000000
`define DELAY_ALL_S 2
`define DELAY_TWO_S 3
`define DELAY_ONE_S 6
`endif

// *** hdl/precharge_pkg.sv ***
// Types shared by the relay delay sequencer
package precharge_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_RUN = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_ONE = 2'b01,
    SEL_TWO = 2'b10,
    SEL_ALL = 2'b11
  } jumper_count_t;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
endpackage

// *** hdl/precharge_relay_delay_sequencer.sv ***
// Relay delay sequencer with AXI4-Lite control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "precharge_regs.svh"
module precharge_relay_delay_sequencer #(
  parameter int unsigned CYCLES_PER_SECOND = `CLOCK_HZ,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Controller and cell monitor pins
  input wire logic relay_drive,
  input wire logic over_charge_threshold_hit,
  input wire logic under_voltage_threshold_hit,
  // Delay jumpers, high when shorted
  input wire logic delay_select_jumper_a,
  input wire logic delay_select_jumper_b,
  input wire logic delay_select_jumper_c,
  // Relay coils
  output logic charge_relay,
  output logic small_discharge_relay,
  output logic large_discharge_relay,
  // Indicators and charger link
  output logic delay_phase_indicator,
  output logic charge_path_indicator,
  output logic run_phase_indicator,
  output logic charger_throttle_request,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned TARGET_ALL = `DELAY_ALL_S * CYCLES_PER_SECOND;
  localparam int unsigned TARGET_TWO = `DELAY_TWO_S * CYCLES_PER_SECOND;
  localparam int unsigned TARGET_ONE = `DELAY_ONE_S * CYCLES_PER_SECOND;
  localparam int PIN_COUNT = 6;
  // Pin synchronisers, one per pin
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  assign pin_raw = {under_voltage_threshold_hit, over_charge_threshold_hit,
                    delay_select_jumper_c, delay_select_jumper_b,
                    delay_select_jumper_a, relay_drive};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate
  logic drive_s;
  logic [2:0] jumpers_s;
  logic over_charge_s;
  logic under_voltage_s;
  assign drive_s = pin_sync[0];
  assign jumpers_s = pin_sync[3:1];
  assign over_charge_s = pin_sync[4];
  assign under_voltage_s = pin_sync[5];
  // Control register
  logic [1:0] ctrl;
  logic seq_enable;
  logic charger_compatible;
  assign seq_enable = ctrl[`CTRL_ENABLE_BIT];
  assign charger_compatible = ctrl[`CTRL_COMPAT_BIT];
  // Jumper decode
  precharge_pkg::jumper_count_t jumper_count;
  logic [31:0] next_target;
  always_comb begin
    jumper_count = precharge_pkg::jumper_count_t'(2'({1'b0, jumpers_s[0]}
                   + {1'b0, jumpers_s[1]} + {1'b0, jumpers_s[2]}));
    case (jumper_count)
      precharge_pkg::SEL_ALL: next_target = 32'(TARGET_ALL);
      precharge_pkg::SEL_TWO: next_target = 32'(TARGET_TWO);
      precharge_pkg::SEL_ONE: next_target = 32'(TARGET_ONE);
      // No jumper fitted: fall back to the longest, gentlest delay
      default: next_target = 32'(TARGET_ONE);
    endcase
  end
  // Sequencer
  precharge_pkg::seq_state_t state;
  logic [31:0] elapsed;
  logic [31:0] target;
  logic [1:0] sel_latched;
  logic active;
  logic start;
  logic delay_done;
  assign active = drive_s && seq_enable;
  assign start = active && (state == precharge_pkg::SEQ_IDLE);
  assign delay_done = (state == precharge_pkg::SEQ_DELAY) && (elapsed == target - 32'h1);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= precharge_pkg::SEQ_IDLE;
    end else if (!active) begin
      state <= precharge_pkg::SEQ_IDLE;
    end else begin
      case (state)
        precharge_pkg::SEQ_IDLE: state <= precharge_pkg::SEQ_DELAY;
        precharge_pkg::SEQ_DELAY: begin
          if (delay_done) begin
            state <= precharge_pkg::SEQ_RUN;
          end
        end
        precharge_pkg::SEQ_RUN: state <= precharge_pkg::SEQ_RUN;
        default: state <= precharge_pkg::SEQ_IDLE;
      endcase
    end
  end
  // Delay timer; jumpers only matter at sequence start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      elapsed <= 32'h0;
      target <= 32'h0;
      sel_latched <= 2'h0;
    end else if (!active) begin
      elapsed <= 32'h0;
    end else if (start) begin
      elapsed <= 32'h0;
      target <= next_target;
      sel_latched <= jumper_count;
    end else if (state == precharge_pkg::SEQ_DELAY) begin
      elapsed <= elapsed + 32'h1;
    end
  end
  // Relay coils
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      charge_relay <= 1'b0;
      small_discharge_relay <= 1'b0;
      large_discharge_relay <= 1'b0;
    end else if (!active) begin
      charge_relay <= 1'b0;
      small_discharge_relay <= 1'b0;
      large_discharge_relay <= 1'b0;
    end else begin
      // On over-charge a throttling charger keeps its path; any other charger is cut off
      charge_relay <= !(over_charge_s && !charger_compatible);
      small_discharge_relay <= start || (state == precharge_pkg::SEQ_DELAY && !delay_done);
      large_discharge_relay <= delay_done || (state == precharge_pkg::SEQ_RUN);
    end
  end

  // Indicators and charger notification
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      charge_path_indicator <= 1'b0;
      delay_phase_indicator <= 1'b0;
      run_phase_indicator <= 1'b0;
      charger_throttle_request <= 1'b0;
    end else begin
      charge_path_indicator <= charge_relay && !over_charge_s;
      delay_phase_indicator <= small_discharge_relay && !under_voltage_s;
      run_phase_indicator <= large_discharge_relay && !under_voltage_s;
      charger_throttle_request <= active && over_charge_s && charger_compatible;
    end
  end

  // AXI4-Lite write side; address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held && s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held && s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= precharge_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr == ADDR_W'(`REG_CTRL)) ? precharge_pkg::RESP_OKAY
                     : precharge_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
    end else if (do_write && aw_addr == ADDR_W'(`REG_CTRL) && w_strb[0]) begin
      ctrl <= w_data[1:0];
    end
  end

  // AXI4-Lite read side
  logic [31:0] read_value;
  logic read_hit;
  always_comb begin
    read_value = 32'h0;
    read_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_W'(`REG_CTRL): read_value = {30'h0, ctrl};
      ADDR_W'(`REG_STATUS): begin
        read_value[`ST_STATE_LSB +: 2] = state;
        read_value[`ST_CHARGE_BIT] = charge_relay;
        read_value[`ST_SMALL_BIT] = small_discharge_relay;
        read_value[`ST_LARGE_BIT] = large_discharge_relay;
        read_value[`ST_NOTIFY_BIT] = charger_throttle_request;
        read_value[`ST_SEL_LSB +: 2] = sel_latched;
      end
      ADDR_W'(`REG_ELAPSED): read_value = elapsed;
      ADDR_W'(`REG_TARGET): read_value = target;
      default: read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= precharge_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= read_hit ? precharge_pkg::RESP_OKAY : precharge_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end

  // Checks
  close_at_once_a: assert property (@(posedge clock) disable iff (!rst_n)
    start |=> small_discharge_relay && !large_discharge_relay)
    else $error("small relay not closed at sequence start");
  large_after_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(large_discharge_relay) |-> $past(elapsed) == $past(target) - 32'h1)
    else $error("large relay closed before the delay ran out");
  small_opens_a: assert property (@(posedge clock) disable iff (!rst_n)
    large_discharge_relay |-> !small_discharge_relay)
    else $error("small relay still closed with large relay");
  jumper_decode_a: assert property (@(posedge clock) disable iff (!rst_n)
    start && jumpers_s == 3'h7 |=> target == 32'(TARGET_ALL))
    else $error("all jumpers did not select the short delay");
  charge_led_a: assert property (@(posedge clock) disable iff (!rst_n)
    charge_path_indicator |-> $past(charge_relay) && !$past(over_charge_s))
    else $error("charge indicator lit without a closed charge path");
  delay_led_a: assert property (@(posedge clock) disable iff (!rst_n)
    delay_phase_indicator |-> $past(small_discharge_relay) && !$past(under_voltage_s))
    else $error("delay indicator lit outside the delay phase");
  run_led_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(large_discharge_relay) && !under_voltage_s |=> run_phase_indicator
    && !delay_phase_indicator)
    else $error("run indicator did not take over after the delay");
  notify_charger_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && over_charge_s && charger_compatible |=> charger_throttle_request && charge_relay)
    else $error("compatible charger not notified on over-charge");
  plain_charger_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && over_charge_s && !charger_compatible |=> !charge_relay
    && !charger_throttle_request)
    else $error("charge relay kept closed for a plain charger");
  release_all_a: assert property (@(posedge clock) disable iff (!rst_n)
    !active |=> !charge_relay && !small_discharge_relay && !large_discharge_relay
    && elapsed == 32'h0 && state == precharge_pkg::SEQ_IDLE)
    else $error("relays or timer not cleared on drive release");
  timer_steps_a: assert property (@(posedge clock) disable iff (!rst_n)
    state == precharge_pkg::SEQ_DELAY && active && !delay_done |=> elapsed == $past(elapsed) + 32'h1)
    else $error("delay timer missed a local clock cycle");
endmodule // precharge_relay_delay_sequencer
`default_nettype wire

// *** verif/relay_controller_model.sv ***
// Behavioural model of the controller and cell monitor pins feeding the sequencer
`timescale 1ns/1ps
`default_nettype none
module relay_controller_model (
  // Clock
  input wire logic clock,
  // Charger link from the sequencer
  input wire logic charger_throttle_request,
  // Controller and cell monitor pins
  output logic relay_drive,
  output logic over_charge_threshold_hit,
  output logic under_voltage_threshold_hit
);
  initial begin
    relay_drive = 1'b0;
    over_charge_threshold_hit = 1'b0;
    under_voltage_threshold_hit = 1'b0;
  end
  // Pins move just after an edge, as a clocked controller output would
  task automatic drive(input logic v);
    @(posedge clock);
    relay_drive <= v;
  endtask
  // Sets the alarm levels only; charger-side throttling is modelled by charger_backoff
  task automatic cells(input logic oc, input logic uv);
    @(posedge clock);
    over_charge_threshold_hit <= oc;
    under_voltage_threshold_hit <= uv;
  endtask
  // Throttling charger: backs its current off once charger_throttle_request is seen
  // (or after limit cycles without it), so the alarm clears one clock later
  task automatic charger_backoff(input int limit);
    int n;
    n = 0;
    while (charger_throttle_request !== 1'b1 && n < limit) begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    over_charge_threshold_hit <= 1'b0;
  endtask
endmodule // relay_controller_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench for the relay delay sequencer
`timescale 1ns/1ps
`default_nettype none
`include "precharge_regs.svh"
module tb_top;
  // Short second keeps the 6 s delay at 60 cycles
  localparam int CPS = 10;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] jmp = 3'h0;
  wire relay_drive, over_charge_threshold_hit, under_voltage_threshold_hit;
  logic charge_relay, small_discharge_relay, large_discharge_relay, charger_throttle_request;
  logic delay_phase_indicator, charge_path_indicator, run_phase_indicator;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;

  always #20 clock = ~clock;

  relay_controller_model ctl (.clock, .charger_throttle_request, .relay_drive,
    .over_charge_threshold_hit, .under_voltage_threshold_hit);
  precharge_relay_delay_sequencer #(.CYCLES_PER_SECOND(CPS)) uut (.clock, .rst_n, .relay_drive,
    .over_charge_threshold_hit, .under_voltage_threshold_hit, .delay_select_jumper_a(jmp[0]),
    .delay_select_jumper_b(jmp[1]), .delay_select_jumper_c(jmp[2]), .charge_relay,
    .small_discharge_relay, .large_discharge_relay, .delay_phase_indicator,
    .charge_path_indicator, .run_phase_indicator, .charger_throttle_request, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic summarize;
    $display("Compares %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  // Hung slave or stuck sequence ends the run here
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(`REG_CTRL, d, r);
    chk(d, 32'h1);
    wr(`REG_STATUS, 32'hFF, r);
    chk(r, precharge_pkg::RESP_SLVERR);
    rd(8'h10, d, r);
    chk(r, precharge_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    wr(`REG_CTRL, 32'h3, r);
    chk(r, precharge_pkg::RESP_OKAY);
    rd(`REG_CTRL, d, r);
    chk(d, 32'h3);
    wr(`REG_CTRL, 32'h1, r);
    $display("Register test done");
  endtask

  task automatic t_delay(input logic [2:0] p);
    int t;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    case ($countones(p))
      3: t = 2 * CPS;
      2: t = 3 * CPS;
      default: t = 6 * CPS;
    endcase
    @(posedge clock);
    jmp <= p;
    ctl.drive(1'b1);
    n = 0;
    while (small_discharge_relay !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    chk(charge_relay, 1'b1);
    chk(large_discharge_relay, 1'b0);
    // Flipping jumpers mid-run must not move the close point
    @(posedge clock);
    jmp <= ~p;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n == 1) chk(delay_phase_indicator, 1'b1);
    end while (large_discharge_relay !== 1'b1 && n < 100);
    chk(n, t);
    chk(small_discharge_relay, 1'b0);
    @(negedge clock);
    chk(run_phase_indicator, 1'b1);
    chk(delay_phase_indicator, 1'b0);
    chk(charge_path_indicator, 1'b1);
    ctl.drive(1'b0);
    // Indicators trail the relays by one cycle
    repeat (5) @(negedge clock);
    chk({charge_relay, small_discharge_relay, large_discharge_relay}, 32'h0);
    chk({delay_phase_indicator, charge_path_indicator, run_phase_indicator}, 32'h0);
    rd(`REG_ELAPSED, d, r);
    chk(d, 32'h0);
    rd(`REG_TARGET, d, r);
    chk(d, t);
    rd(`REG_STATUS, d, r);
    chk(d, 32'($countones(p)) << `ST_SEL_LSB);
    $display("Delay test done for jumpers %b", p);
  endtask

  task automatic t_fault;
    logic [31:0] d;
    logic [1:0] r;
    wr(`REG_CTRL, 32'h3, r);
    @(posedge clock);
    jmp <= 3'h1;
    ctl.drive(1'b1);
    repeat (6) @(negedge clock);
    ctl.cells(1'b1, 1'b0);
    repeat (5) @(negedge clock);
    chk(charger_throttle_request, 1'b1);
    chk(charge_relay, 1'b1);
    chk(charge_path_indicator, 1'b0);
    chk(delay_phase_indicator, 1'b1);
    // Delay state, charge and small relays, throttle, one jumper latched
    rd(`REG_STATUS, d, r);
    chk(d, 32'h6D);
    wr(`REG_CTRL, 32'h1, r);
    repeat (5) @(negedge clock);
    chk(charge_relay, 1'b0);
    chk(charger_throttle_request, 1'b0);
    ctl.cells(1'b0, 1'b1);
    repeat (5) @(negedge clock);
    chk(delay_phase_indicator, 1'b0);
    wr(`REG_CTRL, 32'h3, r);
    ctl.cells(1'b1, 1'b0);
    ctl.charger_backoff(20);
    @(negedge clock);
    chk(charger_throttle_request, 1'b1);
    repeat (4) @(negedge clock);
    chk(charger_throttle_request, 1'b0);
    chk(charge_path_indicator, 1'b1);
    ctl.cells(1'b0, 1'b0);
    ctl.drive(1'b0);
    repeat (4) @(negedge clock);
    $display("Fault test done");
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    for (int i = 0; i < 8; i++) begin
      t_delay(3'(7 - i));
    end
    t_fault();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
